// ### exec_monitor_pkg.sv
/*
 * constants for the execution monitor: register offsets, fields, resets, timing.
 * assumes a 16-bit word register port with plain strobes.
 */
`default_nettype none
package exec_monitor_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned PC_W = 24;
	// ---------------------------------------------
	// register offsets
	// ---------------------------------------------
	localparam logic [15:0] WD_RELOAD_OFS = 16'hF443;
	localparam logic [15:0] WD_DIV_OFS = 16'hF444;
	localparam logic [15:0] FG_IRQ_EN_OFS = 16'hF450;
	localparam logic [15:0] FG_LEN_OFS = 16'hF451;
	localparam logic [15:0] LIVE_PC_HI_OFS = 16'hF460;
	localparam logic [15:0] LIVE_PC_LO_OFS = 16'hF461;
	localparam logic [15:0] PC_RESET_OFS = 16'hF462;
	localparam logic [15:0] FRAME_PEAK_HI_OFS = 16'hF463;
	localparam logic [15:0] FRAME_PEAK_LO_OFS = 16'hF464;
	localparam logic [15:0] ALL_PEAK_HI_OFS = 16'hF465;
	localparam logic [15:0] ALL_PEAK_LO_OFS = 16'hF466;
	localparam logic [15:0] IRQ_STATUS_OFS = 16'hF470;
	localparam logic [15:0] IRQ_MASK_OFS = 16'hF471;
	// ---------------------------------------------
	// fields and resets
	// ---------------------------------------------
	localparam int unsigned DIV_CODE_W = 4;
	localparam int unsigned RELOAD_W = 13;
	localparam int unsigned PRESCALE_W = 18;
	localparam logic [3:0] DIV_CODE_MAX = 4'hB;
	localparam logic [17:0] BASE_PERIOD = 18'h00040;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam int unsigned EN_BIT = 0;
	localparam int unsigned CLR_BIT = 0;
	localparam int unsigned EV_FRAME_GROUP = 0;
	localparam int unsigned EV_WATCHDOG = 1;
	localparam int unsigned EV_W = 2;
endpackage : exec_monitor_pkg
`default_nettype wire

// ### exec_monitor.sv
/*
 * execution monitor beside the core: watchdog prescaler and countdown,
 * frame-group interrupt, program counter observers, sticky event status.
 * assumes frame_start and core_pc are synchronous to sys_clk.
 */
// The strobed register port was chosen for this implementation.
// Operation
// - four-bit divider code: 64 cycles at code 0, doubling to 131072 at 11
// - watchdog timeout equals reload value times selected divider period
// - bit 0 of the enable register gates frame-group interrupts
// - frame counter advances per frame start, compared with 16-bit length
// - at the programmed length raise the interrupt and restart the counter
// - live 24-bit pc readable: upper byte and lower word registers
// - per-frame peak pc recorded, readable across two registers
// - all-time peak pc recorded since start, readable across two registers
// - reset bit set holds pc tracking cleared and frozen
// - setting then clearing the reset bit clears the all-time peak
// - the reset bit also clears the per-frame peak
// - watchdog loads the reload value, counts down, flags error at zero
// - watchdog reload value is 13 bits in bits 12 to 0
`default_nettype none
module exec_monitor
	import exec_monitor_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic frame_start,
	input wire logic wd_restart,
	input wire logic [PC_W-1:0] core_pc,
	output logic frame_group_irq,
	output logic wd_error,
	output logic irq
);
	// ---------------------------------------------
	// register file
	// ---------------------------------------------
	logic [RELOAD_W-1:0] wd_reload_value_ff;
	logic [DIV_CODE_W-1:0] wd_divider_code_ff;
	logic frame_group_irq_on_ff;
	logic [15:0] frame_group_count_ff;
	logic pc_stats_reset_bit_ff;
	logic [EV_W-1:0] irq_status_ff;
	logic [EV_W-1:0] irq_mask_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic irq_ff;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// reserved bits are not stored and read back as zero
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wd_reload_value_ff <= RELOAD_W'(REG_RESET);
			wd_divider_code_ff <= DIV_CODE_W'(REG_RESET);
			frame_group_irq_on_ff <= 1'b0;
			frame_group_count_ff <= REG_RESET;
			pc_stats_reset_bit_ff <= 1'b0;
			irq_mask_ff <= EV_W'(REG_RESET);
		end else if (reg_wr) begin
			if (hit(reg_addr, WD_RELOAD_OFS)) begin
				wd_reload_value_ff <= reg_wdata[RELOAD_W-1:0];
			end
			if (hit(reg_addr, WD_DIV_OFS)) begin
				wd_divider_code_ff <= reg_wdata[DIV_CODE_W-1:0];
			end
			if (hit(reg_addr, FG_IRQ_EN_OFS)) begin
				frame_group_irq_on_ff <= reg_wdata[EN_BIT];
			end
			if (hit(reg_addr, FG_LEN_OFS)) begin
				frame_group_count_ff <= reg_wdata;
			end
			if (hit(reg_addr, PC_RESET_OFS)) begin
				pc_stats_reset_bit_ff <= reg_wdata[CLR_BIT];
			end
			if (hit(reg_addr, IRQ_MASK_OFS)) begin
				irq_mask_ff <= reg_wdata[EV_W-1:0];
			end
		end
	end

	// ---------------------------------------------
	// watchdog prescaler and countdown
	// ---------------------------------------------
	logic [PRESCALE_W-1:0] div_cnt_ff;
	logic [PRESCALE_W-1:0] period_sel;
	logic tick_ff;
	logic [RELOAD_W-1:0] wd_cnt_ff;
	logic wd_error_ff;

	// undefined codes clamp to the longest period rather than wrapping
	always_comb begin
		if (wd_divider_code_ff > DIV_CODE_MAX) begin
			period_sel = BASE_PERIOD << DIV_CODE_MAX;
		end else begin
			period_sel = BASE_PERIOD << wd_divider_code_ff;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			div_cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (wd_restart) begin
			div_cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (div_cnt_ff >= period_sel - 18'h00001) begin
			div_cnt_ff <= '0;
			tick_ff <= 1'b1;
		end else begin
			div_cnt_ff <= div_cnt_ff + 18'h00001;
			tick_ff <= 1'b0;
		end
	end

	// restart from core reloads; total timeout = reload x period
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wd_cnt_ff <= '0;
			wd_error_ff <= 1'b0;
		end else if (wd_restart) begin
			wd_cnt_ff <= wd_reload_value_ff;
			wd_error_ff <= 1'b0;
		end else if (tick_ff && wd_cnt_ff != '0) begin
			wd_cnt_ff <= wd_cnt_ff - 13'h0001;
			wd_error_ff <= (wd_cnt_ff == 13'h0001);
		end else begin
			wd_error_ff <= 1'b0;
		end
	end

	// ---------------------------------------------
	// frame-group counter
	// ---------------------------------------------
	logic [15:0] fg_cnt_ff;
	logic fg_pulse_ff;
	logic [15:0] nxt_fg_cnt;

	assign nxt_fg_cnt = fg_cnt_ff + 16'h0001;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fg_cnt_ff <= '0;
			fg_pulse_ff <= 1'b0;
		end else if (frame_start) begin
			if (nxt_fg_cnt >= frame_group_count_ff) begin
				fg_cnt_ff <= '0;
				fg_pulse_ff <= frame_group_irq_on_ff;
			end else begin
				fg_cnt_ff <= nxt_fg_cnt;
				fg_pulse_ff <= 1'b0;
			end
		end else begin
			fg_pulse_ff <= 1'b0;
		end
	end

	// ---------------------------------------------
	// program counter observers
	// ---------------------------------------------
	logic [PC_W-1:0] live_pc_ff;
	logic [PC_W-1:0] run_peak_ff;
	logic [PC_W-1:0] frame_peak_ff;
	logic [PC_W-1:0] all_peak_ff;

	// the frame peak closes at each frame start; the open frame keeps its own running max
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			live_pc_ff <= '0;
			run_peak_ff <= '0;
			frame_peak_ff <= '0;
			all_peak_ff <= '0;
		end else if (pc_stats_reset_bit_ff) begin
			live_pc_ff <= '0;
			run_peak_ff <= '0;
			frame_peak_ff <= '0;
			all_peak_ff <= '0;
		end else begin
			live_pc_ff <= core_pc;
			if (frame_start) begin
				frame_peak_ff <= run_peak_ff;
				run_peak_ff <= core_pc;
			end else if (core_pc > run_peak_ff) begin
				run_peak_ff <= core_pc;
			end
			if (core_pc > all_peak_ff) begin
				all_peak_ff <= core_pc;
			end
		end
	end

	// ---------------------------------------------
	// event status and interrupt
	// ---------------------------------------------
	logic [EV_W-1:0] ev_set;
	logic [EV_W-1:0] ev_clr;
	logic [EV_W-1:0] nxt_irq_status;
	logic [EV_W-1:0] nxt_irq_mask;

	assign ev_set = {wd_error_ff, fg_pulse_ff};
	assign ev_clr = (reg_wr && hit(reg_addr, IRQ_STATUS_OFS)) ? reg_wdata[EV_W-1:0] : '0;
	// set wins over a write-one clear in the same cycle
	assign nxt_irq_status = (irq_status_ff & ~ev_clr) | ev_set;
	// irq follows the next status and mask, so a mask write never lags a cycle
	assign nxt_irq_mask = (reg_wr && hit(reg_addr, IRQ_MASK_OFS)) ?
		reg_wdata[EV_W-1:0] : irq_mask_ff;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq_status_ff <= '0;
		end else begin
			irq_status_ff <= nxt_irq_status;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_irq_status & nxt_irq_mask);
		end
	end

	// ---------------------------------------------
	// read port
	// ---------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				WD_RELOAD_OFS: rdata_ff <= {3'h0, wd_reload_value_ff};
				WD_DIV_OFS: rdata_ff <= {12'h000, wd_divider_code_ff};
				FG_IRQ_EN_OFS: rdata_ff <= {15'h0000, frame_group_irq_on_ff};
				FG_LEN_OFS: rdata_ff <= frame_group_count_ff;
				LIVE_PC_HI_OFS: rdata_ff <= {8'h00, live_pc_ff[23:16]};
				LIVE_PC_LO_OFS: rdata_ff <= live_pc_ff[15:0];
				PC_RESET_OFS: rdata_ff <= {15'h0000, pc_stats_reset_bit_ff};
				FRAME_PEAK_HI_OFS: rdata_ff <= {8'h00, frame_peak_ff[23:16]};
				FRAME_PEAK_LO_OFS: rdata_ff <= frame_peak_ff[15:0];
				ALL_PEAK_HI_OFS: rdata_ff <= {8'h00, all_peak_ff[23:16]};
				ALL_PEAK_LO_OFS: rdata_ff <= all_peak_ff[15:0];
				IRQ_STATUS_OFS: rdata_ff <= {14'h0000, irq_status_ff};
				IRQ_MASK_OFS: rdata_ff <= {14'h0000, irq_mask_ff};
				default: rdata_ff <= 16'h0000;
			endcase
		end else begin
			rdata_ff <= '0;
		end
	end

	assign reg_rdata = rdata_ff;
	assign frame_group_irq = fg_pulse_ff;
	assign wd_error = wd_error_ff;
	assign irq = irq_ff;

	// ---------------------------------------------
	// check helpers
	// ---------------------------------------------
	// total timeout is judged only while reload and divider stay untouched
	logic [30:0] wd_elapsed_ff;
	logic [30:0] wd_budget_ff;
	logic wd_cfg_kept_ff;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wd_elapsed_ff <= '0;
			wd_budget_ff <= '0;
			wd_cfg_kept_ff <= 1'b0;
		end else if (wd_restart) begin
			wd_elapsed_ff <= '0;
			wd_budget_ff <= 31'(wd_reload_value_ff) * 31'(period_sel);
			wd_cfg_kept_ff <= 1'b1;
		end else begin
			wd_elapsed_ff <= wd_elapsed_ff + 31'h00000001;
			if (reg_wr && (hit(reg_addr, WD_RELOAD_OFS) || hit(reg_addr, WD_DIV_OFS))) begin
				wd_cfg_kept_ff <= 1'b0;
			end
		end
	end

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	sequence s_clear_pulse;
		pc_stats_reset_bit_ff ##1 !pc_stats_reset_bit_ff;
	endsequence

	chk_div_base_period: assert property (@(posedge sys_clk) disable iff (!nrst)
		(wd_divider_code_ff == 4'h0 && !wd_restart) |-> period_sel == 18'h00040)
		else $error("divider code 0 not 64 cycles");
	chk_div_clamp: assert property (@(posedge sys_clk) disable iff (!nrst)
		wd_divider_code_ff > 4'hB |-> period_sel == 18'h20000)
		else $error("undefined divider code not clamped");
	chk_wd_tick_rate: assert property (@(posedge sys_clk) disable iff (!nrst)
		(tick_ff && wd_divider_code_ff == 4'h0) ##1 (wd_divider_code_ff == 4'h0 && !wd_restart)[*8]
		|-> !tick_ff)
		else $error("watchdog ticks faster than divider period");
	chk_wd_load: assert property (@(posedge sys_clk) disable iff (!nrst)
		wd_restart |=> wd_cnt_ff == $past(wd_reload_value_ff))
		else $error("watchdog did not load reload value");
	chk_wd_step: assert property (@(posedge sys_clk) disable iff (!nrst)
		(tick_ff && !wd_restart && wd_cnt_ff != '0) |=> wd_cnt_ff == $past(wd_cnt_ff) - 13'h0001)
		else $error("watchdog did not step down by one");
	chk_wd_error_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
		wd_error_ff |-> wd_cnt_ff == '0)
		else $error("watchdog error without zero count");
	chk_fg_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
		(frame_start && nxt_fg_cnt >= frame_group_count_ff) |=> fg_cnt_ff == '0)
		else $error("frame-group counter not restarted");
	chk_fg_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
		fg_pulse_ff |-> $past(frame_group_irq_on_ff) && $past(frame_start))
		else $error("frame-group interrupt while disabled");
	chk_fg_advance: assert property (@(posedge sys_clk) disable iff (!nrst)
		(frame_start && nxt_fg_cnt < frame_group_count_ff) |=> fg_cnt_ff == $past(fg_cnt_ff) + 16'h0001)
		else $error("frame-group counter did not advance");
	chk_live_pc: assert property (@(posedge sys_clk) disable iff (!nrst)
		!pc_stats_reset_bit_ff |=> live_pc_ff == $past(core_pc))
		else $error("live pc not tracking core");
	chk_frame_peak: assert property (@(posedge sys_clk) disable iff (!nrst)
		(frame_start && !pc_stats_reset_bit_ff) |=> frame_peak_ff == $past(run_peak_ff))
		else $error("frame peak not captured");
	chk_all_peak: assert property (@(posedge sys_clk) disable iff (!nrst)
		!pc_stats_reset_bit_ff |=> all_peak_ff >= $past(core_pc))
		else $error("all-time peak below observed pc");
	chk_clear_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		pc_stats_reset_bit_ff |=> frame_peak_ff == '0 && live_pc_ff == '0)
		else $error("tracking not held cleared");
	chk_clear_seq: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_clear_pulse |-> all_peak_ff == '0)
		else $error("all-time peak not reset by clear sequence");

	sequence s_wd_last_step;
		tick_ff && !wd_restart && wd_cnt_ff == 13'h0001;
	endsequence

	sequence s_live_lo_read;
		reg_rd && reg_addr == LIVE_PC_LO_OFS;
	endsequence

	sequence s_clear_held;
		pc_stats_reset_bit_ff ##1 pc_stats_reset_bit_ff;
	endsequence

	chk_wd_expire: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_wd_last_step |=> wd_error_ff && wd_cnt_ff == '0)
		else $error("watchdog did not flag on the last step");
	chk_wd_total_time: assert property (@(posedge sys_clk) disable iff (!nrst)
		(wd_error_ff && wd_cfg_kept_ff) |-> wd_elapsed_ff == wd_budget_ff + 31'h00000001)
		else $error("watchdog timeout not reload times period");
	chk_wd_idle_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
		(wd_cnt_ff == '0 && !wd_restart) |=> wd_cnt_ff == '0 && !wd_error_ff)
		else $error("expired watchdog moved or flagged again");
	chk_div_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
		tick_ff |-> div_cnt_ff == '0)
		else $error("divider did not restart on tick");
	chk_status_wd: assert property (@(posedge sys_clk) disable iff (!nrst)
		wd_error_ff |=> irq_status_ff[EV_WATCHDOG])
		else $error("watchdog event not recorded");
	chk_status_fg: assert property (@(posedge sys_clk) disable iff (!nrst)
		fg_pulse_ff |=> irq_status_ff[EV_FRAME_GROUP])
		else $error("frame-group event not recorded");
	chk_irq_level: assert property (@(posedge sys_clk) disable iff (!nrst)
		irq_ff == |(irq_status_ff & irq_mask_ff))
		else $error("interrupt level disagrees with status and mask");
	chk_all_peak_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		!pc_stats_reset_bit_ff |=> all_peak_ff >= $past(all_peak_ff))
		else $error("all-time peak decreased");
	chk_run_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
		(frame_start && !pc_stats_reset_bit_ff) |=> run_peak_ff == $past(core_pc))
		else $error("running peak not restarted at frame start");
	chk_live_read: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_live_lo_read |=> rdata_ff == $past(live_pc_ff[15:0]))
		else $error("live pc lower word not returned");
	chk_clear_frozen: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_clear_held |-> all_peak_ff == '0 && run_peak_ff == '0)
		else $error("peaks moved while clear held");
endmodule : exec_monitor
`default_nettype wire

// ### testbench.sv
/*
 * self-checking bench for exec_monitor: register map, frame-group interrupt,
 * watchdog timing, program counter observers, sticky status and mask.
 * assumes the design package and a single 10 MHz clock.
 */
`default_nettype none
module testbench
	import exec_monitor_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, nrst, reg_wr, reg_rd, frame_start, wd_restart;
	logic frame_group_irq, wd_error, irq;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, d, v16;
	logic [23:0] core_pc, run_m, all_m, fpk_m, v;
	logic clr_m, ok;
	int failures, checks_done, seed, fg_n, wd_n, wd_t, cyc, n0, t0, r, p;
	logic [15:0] rw_a[6] = '{WD_RELOAD_OFS, WD_DIV_OFS, FG_IRQ_EN_OFS, FG_LEN_OFS,
		PC_RESET_OFS, IRQ_MASK_OFS};
	logic [15:0] rw_m[6] = '{16'h1FFF, 16'h000F, 16'h0001, 16'hFFFF, 16'h0001, 16'h0003};
	exec_monitor u_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.frame_start(frame_start), .wd_restart(wd_restart), .core_pc(core_pc),
		.frame_group_irq(frame_group_irq), .wd_error(wd_error), .irq(irq));
	initial sys_clk = 1'b0;
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc++;
	// pulse outputs counted mid-cycle, away from the launching edge
	always @(negedge sys_clk) begin
		if (frame_group_irq === 1'b1) fg_n++;
		if (wd_error === 1'b1) begin
			wd_n++;
			wd_t = cyc;
		end
	end
	// ---------------------------------------------
	// bus and check tasks
	// ---------------------------------------------
	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [15:0] w);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rchk(input string n, input logic [15:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(n, e, reg_rdata);
	endtask : rchk
	task automatic frames(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			frame_start <= 1'b1;
			@(posedge sys_clk);
			frame_start <= 1'b0;
			repeat (2) @(posedge sys_clk);
			if (!clr_m) begin
				fpk_m = run_m;
				run_m = 24'h000000;
			end
		end
	endtask : frames
	task automatic set_pc(input logic [23:0] x);
		@(posedge sys_clk);
		core_pc <= x;
		if (!clr_m && x > run_m) run_m = x;
		if (!clr_m && x > all_m) all_m = x;
		repeat (2) @(posedge sys_clk);
	endtask : set_pc
	function automatic int exp_timeout(input int reload, input int code);
		exp_timeout = reload * (int'(BASE_PERIOD) << code);
	endfunction : exp_timeout
	task automatic peaks();
		rchk("frame_hi", FRAME_PEAK_HI_OFS, {8'h00, fpk_m[23:16]});
		rchk("frame_lo", FRAME_PEAK_LO_OFS, fpk_m[15:0]);
		rchk("all_hi", ALL_PEAK_HI_OFS, {8'h00, all_m[23:16]});
		rchk("all_lo", ALL_PEAK_LO_OFS, all_m[15:0]);
	endtask : peaks
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		seed = 23;
		nrst = 1'b0;
		{reg_wr, reg_rd, frame_start, wd_restart, clr_m} = 5'h00;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		core_pc = 24'h000000;
		{run_m, all_m, fpk_m} = '0;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 6; i++) rchk("reset", rw_a[i], REG_RESET);
		for (int i = 0; i < 6; i++) begin
			v16 = 16'($random(seed));
			wr(rw_a[i], v16);
			rchk("rw_mask", rw_a[i], v16 & rw_m[i]);
			wr(rw_a[i], 16'h0000);
		end
		wr(16'hF400, 16'hA5A5);
		rchk("unmapped", 16'hF400, 16'h0000);
		// frame groups of three, then masked/unmasked status
		wr(IRQ_STATUS_OFS, 16'h0003);
		wr(FG_LEN_OFS, 16'h0003);
		wr(FG_IRQ_EN_OFS, 16'h0001);
		for (int i = 1; i <= 3; i++) begin
			n0 = fg_n;
			frames(1);
			chk("fg_pulse", (i == 3), 16'(fg_n - n0));
		end
		rchk("status_set", IRQ_STATUS_OFS, 16'h0001);
		chk("irq_masked", 16'h0000, {15'h0000, irq});
		wr(IRQ_MASK_OFS, 16'h0001);
		@(negedge sys_clk);
		chk("irq_on", 16'h0001, {15'h0000, irq});
		wr(IRQ_STATUS_OFS, 16'h0001);
		@(negedge sys_clk);
		chk("irq_off", 16'h0000, {15'h0000, irq});
		wr(FG_IRQ_EN_OFS, 16'h0000);
		n0 = fg_n;
		frames(3);
		chk("fg_disabled", 16'h0000, 16'(fg_n - n0));
		wr(FG_LEN_OFS, 16'h0001);
		wr(FG_IRQ_EN_OFS, 16'h0001);
		n0 = fg_n;
		frames(2);
		chk("fg_len1", 16'h0002, 16'(fg_n - n0));
		wr(IRQ_STATUS_OFS, 16'h0003);
		wr(WD_DIV_OFS, 16'h000F);
		rchk("div_code_f", WD_DIV_OFS, 16'h000F);
		// watchdog: small reloads over the first three divider codes
		for (int k = 0; k < 3; k++) begin
			r = 1 + ($unsigned($random(seed)) % 3);
			p = exp_timeout(1, k);
			wr(WD_RELOAD_OFS, 16'(r));
			wr(WD_DIV_OFS, 16'(k));
			n0 = wd_n;
			@(posedge sys_clk);
			wd_restart <= 1'b1;
			@(posedge sys_clk);
			wd_restart <= 1'b0;
			@(negedge sys_clk);
			t0 = cyc - 1;
			for (int i = 0; i < r * p + 20 && wd_n == n0; i++) @(posedge sys_clk);
			if (wd_n == n0) begin
				failures++;
				$display("[FAIL] wd_wait expected error seen none");
				summarize();
			end
			ok = (wd_t - t0 >= r * p - 2) && (wd_t - t0 <= r * p + 3);
			chk("wd_time", 16'h0001, {15'h0000, ok});
		end
		n0 = wd_n;
		repeat (300) @(posedge sys_clk);
		chk("wd_once", 16'h0000, 16'(wd_n - n0));
		rchk("wd_status", IRQ_STATUS_OFS, 16'h0002);
		chk("irq_wd_masked", 16'h0000, {15'h0000, irq});
		wr(IRQ_MASK_OFS, 16'h0002);
		@(negedge sys_clk);
		chk("irq_wd", 16'h0001, {15'h0000, irq});
		// live pc and peak trackers
		for (int f = 0; f < 2; f++) begin
			for (int j = 0; j < 4; j++) begin
				v = 24'($random(seed));
				set_pc(v);
				rchk("live_hi", LIVE_PC_HI_OFS, {8'h00, v[23:16]});
				rchk("live_lo", LIVE_PC_LO_OFS, v[15:0]);
			end
			set_pc(24'h000000);
			frames(1);
			peaks();
		end
		// clear holds everything at zero, even across a frame
		wr(PC_RESET_OFS, 16'h0001);
		clr_m = 1'b1;
		{run_m, all_m, fpk_m} = '0;
		peaks();
		set_pc(24'hFFFFFF);
		frames(1);
		peaks();
		set_pc(24'h000000);
		wr(PC_RESET_OFS, 16'h0000);
		clr_m = 1'b0;
		set_pc(24'($random(seed)) & 24'h00FFFF);
		set_pc(24'h000000);
		frames(1);
		peaks();
		summarize();
	end
endmodule : testbench
`default_nettype wire
